// File: oscp_pkg.sv
package oscp_pkg;
	localparam logic [7:0] OSCP_SRC_IDX = 8'h63;
	localparam logic [7:0] OSCP_FILT_IDX = 8'h68;
	localparam logic [7:0] OSCP_LOCK_IDX = 8'h69;
	localparam logic [7:0] OSCP_VCO_IDX = 8'h6a;
	localparam logic [7:0] OSCP_SRC_RST = 8'h00;
	localparam logic [7:0] OSCP_FILT_RST = 8'h8b;
	localparam logic [7:0] OSCP_LOCK_RST = 8'h02;
	localparam logic [7:0] OSCP_VCO_RST = 8'h2b;
	localparam logic [7:0] OSCP_SRC_MASK = 8'hb3;
	localparam logic [7:0] OSCP_LOCK_MASK = 8'h1b;
	localparam int OSCP_SYNC_BIT = 7;
	localparam int OSCP_SEL3_LSB = 4;
	localparam int OSCP_SEL2_LSB = 0;
	localparam int OSCP_CP_LSB = 5;
	localparam int OSCP_RS_LSB = 3;
	localparam int OSCP_CAP_LSB = 1;
	localparam int OSCP_POST_BIT = 0;
	localparam int OSCP_TDC_BIT = 4;
	localparam int OSCP_SYN_BIT = 3;
	localparam int OSCP_CNT_BIT = 1;
	localparam int OSCP_MAN_BIT = 0;
	localparam int OSCP_VCO_LSB = 5;
	localparam logic [9:0] OSCP_PUMP_STEP_UA = 10'h06e;
	typedef enum logic [1:0] {
		OSCP_SRC_PLL = 2'b00,
		OSCP_SRC_REF0 = 2'b01,
		OSCP_SRC_REF1 = 2'b10,
		OSCP_SRC_XTAL = 2'b11
	} oscp_src_t;
	typedef struct packed {
		logic [9:0] pump_ua;
		logic [1:0] series_resistor_code;
		logic [1:0] parallel_cap_code;
		logic post_filter_select;
		logic time_digitizer_off;
		logic crystal_synth_select;
		logic lock_counter_is_16;
		logic lock_manual_override;
		logic [2:0] manual_vco_choice;
		logic [4:0] manual_lock_word;
	} oscp_analog_t;
endpackage : oscp_pkg

// File: oscp_ctrl.sv
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
module oscp_ctrl
	import oscp_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic divider_hold,
	output logic divider_restart,
	output oscp_src_t output_source_select2,
	output oscp_src_t output_source_select3,
	output oscp_analog_t analog_cfg,
	output logic lock_manual_active,
	output logic [2:0] lock_vco_choice,
	output logic [4:0] lock_word
);
	////////////////////////////////////////////////////////////////
	logic [7:0] src_q, src_d, filt_q, filt_d, lock_q, lock_d, vco_q, vco_d;
	logic ack_q, err_q, sync_prev_q, restart_q;
	logic [31:0] rdat_q;
	wire req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire [7:0] idx = wb_adr_i[9:2];
	wire hit_src = idx == OSCP_SRC_IDX;
	wire hit_filt = idx == OSCP_FILT_IDX;
	wire hit_lock = idx == OSCP_LOCK_IDX;
	wire hit_vco = idx == OSCP_VCO_IDX;
	wire mapped = hit_src || hit_filt || hit_lock || hit_vco;
	wire wr_lane = req && wb_we_i && wb_sel_i[0];
	// Reserved bits are not stored, so they always read zero.
	wire [7:0] rsel = hit_src ? src_q : hit_filt ? filt_q : hit_lock ? lock_q :
		hit_vco ? vco_q : 8'h00;

	function automatic logic [7:0] wr_merge(input logic hit, input logic [7:0] old,
		input logic [7:0] mask);
		wr_merge = (hit && wr_lane) ? (wb_dat_i[7:0] & mask) : old;
	endfunction : wr_merge

	always_comb begin
		src_d = wr_merge(hit_src, src_q, OSCP_SRC_MASK);
		filt_d = wr_merge(hit_filt, filt_q, 8'hff);
		lock_d = wr_merge(hit_lock, lock_q, OSCP_LOCK_MASK);
		vco_d = wr_merge(hit_vco, vco_q, 8'hff);
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!resetn) begin
			src_q <= OSCP_SRC_RST;
			filt_q <= OSCP_FILT_RST;
			lock_q <= OSCP_LOCK_RST;
			vco_q <= OSCP_VCO_RST;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdat_q <= 32'h0;
			sync_prev_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			src_q <= src_d;
			filt_q <= filt_d;
			lock_q <= lock_d;
			vco_q <= vco_d;
			ack_q <= req && mapped;
			err_q <= req && !mapped;
			rdat_q <= {24'h0, rsel};
			sync_prev_q <= src_q[OSCP_SYNC_BIT];
			restart_q <= sync_prev_q && !src_q[OSCP_SYNC_BIT];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = ack_q ? rdat_q : 32'h0;

	////////////////////////////////////////////////////////////////
	// Hold spans the whole time the sync bit is set; the release is one shared pulse
	// so every affected divider starts from the same edge with coarse phase zero.
	assign divider_hold = src_q[OSCP_SYNC_BIT];
	assign divider_restart = restart_q;
	assign output_source_select2 = oscp_src_t'(src_q[OSCP_SEL2_LSB +: 2]);
	assign output_source_select3 = oscp_src_t'(src_q[OSCP_SEL3_LSB +: 2]);

	wire [2:0] pump_code = filt_q[OSCP_CP_LSB +: 3];
	always_comb begin
		analog_cfg.pump_ua = 10'(({7'h0, pump_code} + 10'h001) * OSCP_PUMP_STEP_UA);
		analog_cfg.series_resistor_code = filt_q[OSCP_RS_LSB +: 2];
		analog_cfg.parallel_cap_code = filt_q[OSCP_CAP_LSB +: 2];
		analog_cfg.post_filter_select = filt_q[OSCP_POST_BIT];
		analog_cfg.time_digitizer_off = lock_q[OSCP_TDC_BIT];
		analog_cfg.crystal_synth_select = lock_q[OSCP_SYN_BIT];
		analog_cfg.lock_counter_is_16 = lock_q[OSCP_CNT_BIT];
		analog_cfg.lock_manual_override = lock_q[OSCP_MAN_BIT];
		analog_cfg.manual_vco_choice = vco_q[OSCP_VCO_LSB +: 3];
		analog_cfg.manual_lock_word = vco_q[4:0];
	end

	// Manual values reach lock_vco_choice and lock_word only while the override is set; analog_cfg always carries them.
	assign lock_manual_active = lock_q[OSCP_MAN_BIT];
	assign lock_vco_choice = lock_q[OSCP_MAN_BIT] ? vco_q[OSCP_VCO_LSB +: 3] : 3'h0;
	assign lock_word = lock_q[OSCP_MAN_BIT] ? vco_q[4:0] : 5'h00;

	////////////////////////////////////////////////////////////////
	sync_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(src_q[OSCP_SYNC_BIT])
		|-> divider_hold [*2])
		else $error("divider hold missing after sync set");

	hold_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_src
		|=> divider_hold == $past(wb_dat_i[OSCP_SYNC_BIT]))
		else $error("divider hold does not follow sync bit");

	restart_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(divider_hold)
		|=> divider_restart ##1 !divider_restart)
		else $error("divider restart not a single pulse");

	restart_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		divider_restart
		|-> !divider_hold && $past(divider_hold, 2))
		else $error("restart without sync release");

	restart_single_a: assert property (@(posedge clk) disable iff (!resetn)
		divider_restart
		|=> !divider_restart)
		else $error("restart pulse longer than one cycle");

	restart_idle_a: assert property (@(posedge clk) disable iff (!resetn)
		divider_hold
		|-> !divider_restart)
		else $error("restart while dividers held");

	src_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_src
		|=> output_source_select3 == oscp_src_t'($past(wb_dat_i[5:4])))
		else $error("source select not updated");

	src2_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_src
		|=> output_source_select2 == oscp_src_t'($past(wb_dat_i[1:0])))
		else $error("second source select not updated");

	src_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wr_lane && hit_src)
		|=> $stable(src_q))
		else $error("source register changed without write");

	src_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
		(src_q & ~OSCP_SRC_MASK)
		== 8'h00)
		else $error("source reserved bits stored");

	filt_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_filt |=> analog_cfg.post_filter_select == $past(wb_dat_i[0]) &&
		analog_cfg.series_resistor_code == $past(wb_dat_i[4:3]))
		else $error("filter fields not updated");

	cap_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_filt
		|=> analog_cfg.parallel_cap_code == $past(wb_dat_i[2:1]))
		else $error("capacitor code not updated");

	pump_top_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_filt && wb_dat_i[7:5] == 3'h7
		|=> analog_cfg.pump_ua == 10'h370)
		else $error("pump current wrong at top code");

	pump_low_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_filt && wb_dat_i[7:5] == 3'h0
		|=> analog_cfg.pump_ua == 10'h06e)
		else $error("pump current wrong at bottom code");

	pump_scale_a: assert property (@(posedge clk) disable iff (!resetn)
		analog_cfg.pump_ua >= 10'h06e &&
		analog_cfg.pump_ua <= 10'h370)
		else $error("pump current out of range");

	pump_step_a: assert property (@(posedge clk) disable iff (!resetn)
		analog_cfg.pump_ua % 10'h06e
		== 10'h000)
		else $error("pump current off the step grid");

	filt_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wr_lane && hit_filt)
		|=> $stable(filt_q))
		else $error("filter register changed without write");

	lock_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_lock |=> lock_manual_active == $past(wb_dat_i[0]) &&
		analog_cfg.crystal_synth_select == $past(wb_dat_i[3]))
		else $error("lock controls not updated");

	tdc_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_lock
		|=> analog_cfg.time_digitizer_off == $past(wb_dat_i[4]))
		else $error("time digitizer control not updated");

	cnt_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_lock
		|=> analog_cfg.lock_counter_is_16 == $past(wb_dat_i[1]))
		else $error("lock counter width not updated");

	lock_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wr_lane && hit_lock)
		|=> $stable(lock_q))
		else $error("lock register changed without write");

	lock_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
		(lock_q & ~OSCP_LOCK_MASK)
		== 8'h00)
		else $error("lock reserved bits stored");

	vco_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_vco
		|=> analog_cfg.manual_lock_word == $past(wb_dat_i[4:0]))
		else $error("lock word not updated");

	vco_choice_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lane && hit_vco
		|=> analog_cfg.manual_vco_choice == $past(wb_dat_i[7:5]))
		else $error("vco choice not updated");

	vco_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wr_lane && hit_vco)
		|=> $stable(vco_q))
		else $error("vco register changed without write");

	manual_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		!lock_manual_active
		|-> lock_word == 5'h00 && lock_vco_choice == 3'h0)
		else $error("manual word leaks in auto mode");

	manual_pass_a: assert property (@(posedge clk) disable iff (!resetn)
		lock_manual_active |-> lock_word == analog_cfg.manual_lock_word &&
		lock_vco_choice == analog_cfg.manual_vco_choice)
		else $error("manual values not passed in manual mode");

	manual_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		lock_manual_active
		== analog_cfg.lock_manual_override)
		else $error("manual flag disagrees with override");

	bus_answer_a: assert property (@(posedge clk) disable iff (!resetn)
		req
		|=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");

	ack_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		wb_ack_o
		|=> !wb_ack_o)
		else $error("ack longer than one cycle");

	err_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		wb_err_o
		|=> !wb_err_o)
		else $error("err longer than one cycle");

	ack_err_excl_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wb_ack_o
		&& wb_err_o))
		else $error("ack and err together");

	idle_data_a: assert property (@(posedge clk) disable iff (!resetn)
		!wb_ack_o
		|-> wb_dat_o == 32'h0)
		else $error("read data outside ack");

	data_upper_a: assert property (@(posedge clk) disable iff (!resetn)
		wb_dat_o[31:8]
		== 24'h0)
		else $error("upper read data not zero");

	ack_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		wb_ack_o
		|-> $past(req) && $past(mapped))
		else $error("ack without mapped request");

	err_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		wb_err_o
		|-> $past(req) && !$past(mapped))
		else $error("err without unmapped request");

	no_request_a: assert property (@(posedge clk) disable iff (!resetn)
		!(wb_cyc_i && wb_stb_i)
		|=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");

	read_src_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !wb_we_i && hit_src
		|=> wb_dat_o[7:0] == $past(src_q))
		else $error("source read data wrong");

	read_filt_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !wb_we_i && hit_filt
		|=> wb_dat_o[7:0] == $past(filt_q))
		else $error("filter read data wrong");

	read_lock_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !wb_we_i && hit_lock
		|=> wb_dat_o[7:0] == $past(lock_q))
		else $error("lock read data wrong");

	read_vco_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !wb_we_i && hit_vco
		|=> wb_dat_o[7:0] == $past(vco_q))
		else $error("vco read data wrong");

	unmapped_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !mapped |=> $stable(src_q) && $stable(filt_q) &&
		$stable(lock_q) && $stable(vco_q))
		else $error("unmapped access changed a register");

	lane_off_a: assert property (@(posedge clk) disable iff (!resetn)
		req && wb_we_i && !wb_sel_i[0] |=> $stable(src_q) && $stable(filt_q) &&
		$stable(lock_q) && $stable(vco_q))
		else $error("write without lane changed a register");

	read_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		req && !wb_we_i |=> $stable(src_q) && $stable(filt_q) &&
		$stable(lock_q) && $stable(vco_q))
		else $error("read changed a register");

	reset_default_a: assert property (@(posedge clk)
		!resetn |=> analog_cfg.lock_counter_is_16 && analog_cfg.post_filter_select &&
		analog_cfg.manual_vco_choice == 3'h1 && !divider_hold)
		else $error("defaults not loaded");

	reset_src_a: assert property (@(posedge clk)
		!resetn |=> output_source_select2 == OSCP_SRC_PLL &&
		output_source_select3 == OSCP_SRC_PLL)
		else $error("source select default not loaded");

	reset_pump_a: assert property (@(posedge clk)
		!resetn |=> analog_cfg.pump_ua == 10'h226 &&
		analog_cfg.series_resistor_code == 2'h1 && analog_cfg.parallel_cap_code == 2'h1)
		else $error("filter defaults not loaded");

	reset_lock_a: assert property (@(posedge clk)
		!resetn |=> !analog_cfg.time_digitizer_off && !analog_cfg.crystal_synth_select &&
		!analog_cfg.lock_manual_override && analog_cfg.manual_lock_word == 5'h0b)
		else $error("lock defaults not loaded");

	reset_bus_a: assert property (@(posedge clk)
		!resetn |=> !wb_ack_o && !wb_err_o &&
		!divider_restart && wb_dat_o == 32'h0)
		else $error("bus outputs not idle after reset");
endmodule : oscp_ctrl

// File: output_source_and_pll_config_bench.sv
`timescale 1ns/10ps
module output_source_and_pll_config_bench;
	import oscp_pkg::*;
	logic clk, resetn, cyc, we, ack, err, hold, rst_p, man;
	logic [7:0] idx_q, wd;
	logic [31:0] rdat;
	logic [2:0] vco;
	logic [4:0] word;
	logic [3:0] sel;
	oscp_src_t s2, s3;
	oscp_analog_t cfg;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int pulses = 0;
	oscp_ctrl u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i({idx_q, 2'b00}), .wb_sel_i(sel), .wb_dat_i({24'h000000, wd}),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .divider_hold(hold),
		.divider_restart(rst_p), .output_source_select2(s2), .output_source_select3(s3),
		.analog_cfg(cfg), .lock_manual_active(man), .lock_vco_choice(vco), .lock_word(word));
////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The run needs well under a thousand cycles; this ceiling only cuts a hang.
	always @(posedge clk) begin
		cycles++;
		if (rst_p === 1'b1) pulses++;
		if (cycles == 3000) begin
			num_errors++;
			finish_test();
		end
	end
////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// The request stands unchanged until ack or err is seen at a rising edge.
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		idx_q <= i;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		e = err;
		cyc <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		bus(1'b1, i, d, q, e);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] exp);
		logic [31:0] q;
		logic e;
		bus(1'b0, i, 8'h00, q, e);
		chk(nm, {24'h000000, exp}, q);
	endtask : rd
	function automatic logic [31:0] flg();
		return {27'h0, cfg.post_filter_select, cfg.time_digitizer_off,
			cfg.crystal_synth_select, cfg.lock_counter_is_16, cfg.lock_manual_override};
	endfunction : flg
////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		rd("source reg", OSCP_SRC_IDX, 8'h00);
		rd("filter reg", OSCP_FILT_IDX, 8'h8b);
		rd("lock reg", OSCP_LOCK_IDX, 8'h02);
		rd("vco reg", OSCP_VCO_IDX, 8'h2b);
		chk("pump ua", 32'h226, 32'(cfg.pump_ua));
		chk("codes", 32'h5, {28'h0, cfg.series_resistor_code, cfg.parallel_cap_code});
		chk("mode bits", 32'h12, flg());
		chk("hold", 32'h0, {31'h0, hold});
	endtask : t_defaults
	task automatic t_filter();
		for (int i = 0; i < 8; i++) begin
			wr(OSCP_FILT_IDX, 8'(i << 5));
			chk("pump ua", 32'((i + 1) * 32'h6e), 32'(cfg.pump_ua));
		end
		wr(OSCP_FILT_IDX, 8'h1e);
		chk("codes", 32'hf, {28'h0, cfg.series_resistor_code, cfg.parallel_cap_code});
		chk("mode bits", 32'h02, flg());
	endtask : t_filter
	// Both references are taken as slower than 250 MHz here, so direct routing is legal.
	task automatic t_source();
		for (int i = 0; i < 4; i++) begin
			wr(OSCP_SRC_IDX, 8'(i) | 8'((3 - i) << 4));
			chk("select2", 32'(i), 32'(s2));
			chk("select3", 32'(3 - i), 32'(s3));
			rd("source reg", OSCP_SRC_IDX, 8'(i) | 8'((3 - i) << 4));
		end
	endtask : t_source
	task automatic t_sync();
		int p;
		wr(OSCP_SRC_IDX, 8'h80);
		p = pulses;
		repeat (5) @(posedge clk);
		chk("hold set", 32'h1, {31'h0, hold});
		wr(OSCP_SRC_IDX, 8'h00);
		repeat (6) @(posedge clk);
		chk("hold clear", 32'h0, {31'h0, hold});
		chk("restarts", 32'(p + 1), 32'(pulses));
	endtask : t_sync
	task automatic t_lock();
		logic [31:0] q;
		logic e;
		// The digital PLL state field lives outside this block and is taken as free-run.
		wr(OSCP_LOCK_IDX, 8'h1b);
		rd("lock reg", OSCP_LOCK_IDX, 8'h1b);
		chk("mode bits", 32'h0f, flg());
		wr(OSCP_VCO_IDX, 8'h15);
		chk("manual", 32'h115, {23'h0, man, vco, word});
		sel <= 4'h0;
		wr(OSCP_VCO_IDX, 8'h00);
		sel <= 4'h1;
		rd("vco kept", OSCP_VCO_IDX, 8'h15);
		wr(OSCP_LOCK_IDX, 8'h00);
		chk("auto", 32'h0, {23'h0, man, vco, word} | flg());
		bus(1'b0, 8'h64, 8'h00, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
	endtask : t_lock
////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		idx_q = 8'h00;
		wd = 8'h00;
		sel = 4'h1;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_defaults();
		t_filter();
		t_source();
		t_sync();
		t_lock();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_defaults();
		finish_test();
	end
endmodule : output_source_and_pll_config_bench
